// ---- verilog/bvg_video_gen.sv ----
// bitmap video generator: timing tables, memory arbitration, pixel shifter
// ------------------------------------------------------------
// Notes on behaviour
// R1: display memory holds 20K eight-bit bytes, one bit per pixel.
// R2: memory bytes become a serial pixel stream sent with horizontal and vertical sync.
// R3: processor writes use processor address and the write data bus byte.
// R4: processor reads use processor address; byte goes onto buffered data bus.
// R5: picture fetches refresh the memory; no separate refresh cycle.
// R6: picture fetch address comes from vertical scan and horizontal dot counters.
// R7: scroll start register captures bus byte; loaded into scan counter each frame.
// R8: vertical scan counter advances once per horizontal line.
// R9: dot counter clears at line start and advances once per dot.
// R10: dot counter wrap clocks the vertical timing section.
// R11: processor requests with cpu_display_request; device grants with cpu_cycle_grant.
// R12: control logic drives two row strobes and two column strobes.
// R13: horizontal_sync_out keeps monitor sweep aligned with the pixel stream.
// R14: pixels are blanked while display_blank_control is high.
// R15: regulator_sync pulse is output for the regulator ramp generator.
// R16: two tables addressed by the dot counter give four bits per position.
// R17: low table repeats the eight-slot group from 00 to FF.
// R18: high table repeats group to 3F, waits to 47, cpu at 45, sync from 48.
// R19: processor access occurs only in processor slots.
// R20: vertical blank forces serial pixel data to zeros.
// R21: pending request waits for the next processor slot; grant only in it.
// R22: shifter loads a byte on each load slot and shifts a bit per dot; code does neither while the buffer is full and pixel_ready_i is low.
// ------------------------------------------------------------
module bvg_video_gen
   import bvg_pkg::*;
#(
   parameter int MEM_DEPTH = MEM_BYTES
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // processor memory bus
   input wire logic cpu_display_request_i,
   input wire logic cpu_write_i,
   input wire logic [DATA_W-1:0] buffered_address_bus_i,
   input wire logic [ADDR_W-1-DATA_W:0] upper_address_bus_i,
   input wire logic [DATA_W-1:0] write_data_bus_i,
   input wire logic scroll_write_i,
   input wire logic [DATA_W-1:0] buffered_data_bus_i,
   output logic [DATA_W-1:0] buffered_data_bus_o,
   output logic buffered_data_bus_oe_n_o,
   output logic cpu_cycle_grant_o,
   // display control
   input wire logic display_blank_control_i,
   // pixel stream with back-pressure from the receiver
   input wire logic pixel_ready_i,
   output logic pixel_valid_o,
   output logic pixel_o,
   output logic horizontal_sync_out_o,
   output logic vertical_sync_o,
   output logic vertical_blank_o,
   output logic regulator_sync_o,
   // memory strobes
   output logic row_strobe_a_o,
   output logic row_strobe_b_o,
   output logic col_strobe_a_o,
   output logic col_strobe_b_o
);
   // ------------------------------------------------------------
   // display memory
   // ------------------------------------------------------------
   logic [DATA_W-1:0] mem [MEM_DEPTH]; // R1

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [DOT_W-1:0] dot_ff, nxt_dot;
   logic [SCAN_W-1:0] scan_ff, nxt_scan;
   logic [SCAN_W-1:0] line_ff, nxt_line;
   logic [SCAN_W-1:0] start_ff, nxt_start;
   logic [DATA_W-1:0] fetch_ff, nxt_fetch;
   logic pend_ff, nxt_pend;
   logic grant_ff, nxt_grant;
   logic [DATA_W-1:0] rdata_ff, nxt_rdata;
   logic rd_oe_n_ff, nxt_rd_oe_n;
   logic hs_ff, nxt_hs, vs_ff, nxt_vs, vb_ff, nxt_vb, rs_ff, nxt_rs;
   logic ras_a_ff, ras_b_ff, cas_a_ff, cas_b_ff;
   logic nxt_ras_a, nxt_ras_b, nxt_cas_a, nxt_cas_b;
   // two-entry pixel buffer
   logic [1:0] buf_ff, nxt_buf;
   logic [1:0] cnt_ff, nxt_cnt;
   logic pv_ff, nxt_pv, px_ff, nxt_px;
   logic [DATA_W-1:0] sh_ff, nxt_sh;
   logic [2:0] shcnt_ff, nxt_shcnt;

   bvg_pattern_t pat;
   bvg_slot_t slot;
   logic [7:0] tab_addr;
   logic line_end, mem_en, mem_we;
   logic [ADDR_W-1:0] mem_addr, cpu_addr, disp_addr;
   logic buf_push, buf_pop, stall;
   bvg_cpu_req_t cpu_req;

   // ------------------------------------------------------------
   // horizontal pattern tables
   // ------------------------------------------------------------
   function automatic bvg_pattern_t group_pat(input logic [2:0] s);
      bvg_pattern_t p;
      p = PAT_WAIT;
      unique case (s)
         3'h0, 3'h3: p = PAT_FETCH;
         3'h2, 3'h6: p = PAT_LOAD;
         3'h5: p = PAT_CPU;
         3'h1, 3'h4, 3'h7: p = PAT_WAIT;
      endcase
      return p;
   endfunction : group_pat

   // low half of the line uses the low table, upper half the high table
   assign tab_addr = dot_ff[7:0]; // R16
   always_comb begin
      pat = PAT_WAIT;
      if (!dot_ff[DOT_W-1]) begin
         pat = group_pat(tab_addr[2:0]); // R17
      end else if (tab_addr <= HI_GROUP_END) begin
         pat = group_pat(tab_addr[2:0]); // R18
      end else if (tab_addr <= HI_WAIT_END) begin
         pat.cpu_access_slot = (tab_addr == HI_CPU_SLOT); // R18
      end else if (tab_addr <= HI_SYNC_LAST) begin
         pat.hsync_slot = 1'b1; // R18
         pat.cpu_access_slot = ((tab_addr[2:0] & SYNC_GROUP_MASK) == HI_SYNC_CPU[2:0]);
      end else begin
         pat.cpu_access_slot = (tab_addr[2:0] == HI_SYNC_CPU[2:0]);
      end
   end

   always_comb begin
      if (pat.fetch_display_slot) slot = SLOT_FETCH;
      else if (pat.load_shifter_slot) slot = SLOT_LOAD;
      else if (pat.cpu_access_slot) slot = SLOT_CPU;
      else slot = SLOT_WAIT;
   end

   // ------------------------------------------------------------
   // counters and arbitration
   // ------------------------------------------------------------
   assign line_end = (dot_ff == DOT_LAST);
   assign cpu_addr = {upper_address_bus_i, buffered_address_bus_i}; // R3
   // display address: scan line in high bits, byte column from the dot count
   assign disp_addr = {scan_ff[ADDR_W-DATA_W-1:0], dot_ff[DOT_W-1:1]}; // R6
   assign cpu_req = '{cpu_addr, write_data_bus_i, cpu_write_i};
   // stalled receiver would drop fetched data, so the shifter holds instead
   assign stall = (cnt_ff == 2'd2) && !pixel_ready_i;

   always_comb begin
      nxt_dot = line_end ? DOT_ZERO : dot_ff + DOT_ONE; // R9
      nxt_line = line_ff;
      nxt_scan = scan_ff;
      nxt_start = scroll_write_i ? buffered_data_bus_i : start_ff; // R7
      if (line_end) begin
         nxt_line = line_ff + LINE_ONE; // R10
         nxt_scan = (line_ff == LINE_LAST) ? start_ff : scan_ff + LINE_ONE; // R7 R8
      end
      // the request still seen on the grant edge is the one just served
      nxt_pend = pend_ff | (cpu_display_request_i && !grant_ff); // R11
      nxt_grant = 1'b0;
      if (slot == SLOT_CPU && (pend_ff || cpu_display_request_i)) begin
         nxt_grant = 1'b1; // R21 R19
         nxt_pend = 1'b0;
      end
      nxt_hs = pat.hsync_slot; // R13
      nxt_vb = (line_ff >= VBL_FIRST);
      nxt_vs = (line_ff >= VSYNC_FIRST) && (line_ff <= VSYNC_LAST);
      nxt_rs = pat.hsync_slot && (tab_addr == HI_SYNC_FIRST); // R15
   end

   // ------------------------------------------------------------
   // memory port and strobes
   // ------------------------------------------------------------
   assign mem_en = (slot == SLOT_FETCH) || nxt_grant; // R5
   assign mem_we = nxt_grant && cpu_req.write; // R19
   assign mem_addr = nxt_grant ? cpu_req.addr : disp_addr;

   always_comb begin
      nxt_ras_a = mem_en && !mem_addr[ADDR_W-1];
      nxt_ras_b = mem_en && mem_addr[ADDR_W-1]; // R12
      nxt_cas_a = nxt_ras_a;
      nxt_cas_b = nxt_ras_b;
      nxt_fetch = fetch_ff;
      nxt_rdata = rdata_ff;
      nxt_rd_oe_n = 1'b1;
      if (slot == SLOT_FETCH && int'(mem_addr) < MEM_DEPTH) nxt_fetch = mem[mem_addr];
      if (nxt_grant && !cpu_req.write) begin
         nxt_rdata = (int'(mem_addr) < MEM_DEPTH) ? mem[mem_addr] : '0; // R4
         nxt_rd_oe_n = 1'b0;
      end
   end

   always_ff @(posedge clock_i) begin
      if (mem_we && int'(mem_addr) < MEM_DEPTH) mem[mem_addr] <= cpu_req.data; // R3
   end

   // ------------------------------------------------------------
   // shifter and two-entry pixel buffer
   // ------------------------------------------------------------
   assign buf_push = (cnt_ff != 2'd2) && !stall;
   assign buf_pop = pv_ff && pixel_ready_i;

   always_comb begin
      nxt_sh = sh_ff;
      nxt_shcnt = shcnt_ff;
      nxt_buf = buf_ff;
      nxt_cnt = cnt_ff;
      nxt_pv = pv_ff;
      nxt_px = px_ff;
      if (slot == SLOT_LOAD && !stall) begin
         nxt_sh = fetch_ff; // R22
         nxt_shcnt = BIT_ZERO;
      end else if (!stall) begin
         nxt_sh = {sh_ff[DATA_W-2:0], 1'b0}; // R22
         nxt_shcnt = shcnt_ff + BIT_ONE;
      end
      if (buf_pop) begin
         nxt_buf = {1'b0, buf_ff[1]};
         nxt_cnt = cnt_ff - 2'd1;
      end
      if (buf_push) begin
         // blanking and vertical blank both zero the pixel
         nxt_buf[nxt_cnt[0]] = sh_ff[DATA_W-1] && !display_blank_control_i && !vb_ff; // R14 R20 R2
         nxt_cnt = nxt_cnt + 2'd1;
      end
      nxt_pv = (nxt_cnt != 2'd0);
      nxt_px = nxt_buf[0];
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         dot_ff <= DOT_ZERO;
         line_ff <= LINE_ZERO;
         scan_ff <= LINE_ZERO;
         start_ff <= LINE_ZERO;
         fetch_ff <= '0;
         pend_ff <= 1'b0;
         grant_ff <= 1'b0;
         rdata_ff <= '0;
         rd_oe_n_ff <= 1'b1;
         hs_ff <= 1'b0;
         vs_ff <= 1'b0;
         vb_ff <= 1'b0;
         rs_ff <= 1'b0;
         ras_a_ff <= 1'b0;
         ras_b_ff <= 1'b0;
         cas_a_ff <= 1'b0;
         cas_b_ff <= 1'b0;
         buf_ff <= 2'b00;
         cnt_ff <= 2'd0;
         pv_ff <= 1'b0;
         px_ff <= 1'b0;
         sh_ff <= '0;
         shcnt_ff <= BIT_ZERO;
      end else begin
         dot_ff <= nxt_dot;
         line_ff <= nxt_line;
         scan_ff <= nxt_scan;
         start_ff <= nxt_start;
         fetch_ff <= nxt_fetch;
         pend_ff <= nxt_pend;
         grant_ff <= nxt_grant;
         rdata_ff <= nxt_rdata;
         rd_oe_n_ff <= nxt_rd_oe_n;
         hs_ff <= nxt_hs;
         vs_ff <= nxt_vs;
         vb_ff <= nxt_vb;
         rs_ff <= nxt_rs;
         ras_a_ff <= nxt_ras_a;
         ras_b_ff <= nxt_ras_b;
         cas_a_ff <= nxt_cas_a;
         cas_b_ff <= nxt_cas_b;
         buf_ff <= nxt_buf;
         cnt_ff <= nxt_cnt;
         pv_ff <= nxt_pv;
         px_ff <= nxt_px;
         sh_ff <= nxt_sh;
         shcnt_ff <= nxt_shcnt;
      end
   end

   assign cpu_cycle_grant_o = grant_ff;
   assign buffered_data_bus_o = rdata_ff;
   assign buffered_data_bus_oe_n_o = rd_oe_n_ff;
   assign horizontal_sync_out_o = hs_ff;
   assign vertical_sync_o = vs_ff;
   assign vertical_blank_o = vb_ff;
   assign regulator_sync_o = rs_ff;
   assign row_strobe_a_o = ras_a_ff;
   assign row_strobe_b_o = ras_b_ff;
   assign col_strobe_a_o = cas_a_ff;
   assign col_strobe_b_o = cas_b_ff;
   assign pixel_valid_o = pv_ff;
   assign pixel_o = px_ff;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   sequence line_wrap_s;
      dot_ff == DOT_LAST;
   endsequence
   grant_in_slot_a: assert property (@(posedge clock_i) disable iff (rst_i) // R19
      cpu_cycle_grant_o |-> $past(slot) == SLOT_CPU)
      else $error("grant outside processor slot");
   grant_cause_a: assert property (@(posedge clock_i) disable iff (rst_i) // R11
      $rose(cpu_cycle_grant_o) |-> $past(pend_ff || cpu_display_request_i))
      else $error("grant without request");
   pend_served_a: assert property (@(posedge clock_i) disable iff (rst_i) // R21
      (slot == SLOT_CPU && pend_ff) |=> cpu_cycle_grant_o)
      else $error("pending request not granted");
   dot_clear_a: assert property (@(posedge clock_i) disable iff (rst_i) // R9
      line_wrap_s |=> dot_ff == DOT_ZERO)
      else $error("dot counter not cleared");
   scan_step_a: assert property (@(posedge clock_i) disable iff (rst_i) // R8
      (line_wrap_s and line_ff != LINE_LAST) |=> scan_ff == $past(scan_ff) + LINE_ONE)
      else $error("scan counter did not advance");
   scroll_load_a: assert property (@(posedge clock_i) disable iff (rst_i) // R7
      (line_wrap_s and line_ff == LINE_LAST) |=> scan_ff == $past(start_ff))
      else $error("start scan not loaded");
   hsync_slot_a: assert property (@(posedge clock_i) disable iff (rst_i) // R13
      pat.hsync_slot |=> horizontal_sync_out_o)
      else $error("horizontal sync missing");
   blank_zero_a: assert property (@(posedge clock_i) disable iff (rst_i) // R14
      (buf_push && display_blank_control_i && (cnt_ff - 2'(buf_pop)) == 2'd0) |=> !pixel_o)
      else $error("pixel not blanked");
   strobe_fetch_a: assert property (@(posedge clock_i) disable iff (rst_i) // R12
      (slot == SLOT_FETCH) |=> (row_strobe_a_o || row_strobe_b_o))
      else $error("no strobe on fetch");
   buf_bound_a: assert property (@(posedge clock_i) disable iff (rst_i) // R22
      cnt_ff <= 2'd2)
      else $error("pixel buffer overflow");
endmodule : bvg_video_gen

// ---- pkg/bvg_pkg.sv ----
// package for the bitmap video generator: sizes, slot codes, timing
package bvg_pkg;
   // ------------------------------------------------------------
   // memory geometry
   // ------------------------------------------------------------
   localparam int MEM_BYTES = 20480;
   localparam int ADDR_W = 15;
   localparam int DATA_W = 8;
   localparam int SCAN_W = 8;
   localparam int DOT_W = 9;
   localparam int DOT_W_RANGE = 1 << DOT_W;
   // ------------------------------------------------------------
   // horizontal pattern layout
   // ------------------------------------------------------------
   localparam logic [DOT_W-1:0] DOT_LAST = 9'h1ff;
   localparam logic [DOT_W-1:0] DOT_ZERO = 9'h000;
   localparam logic [DOT_W-1:0] DOT_ONE = 9'h001;
   localparam logic [7:0] HI_GROUP_END = 8'h3f;
   localparam logic [7:0] HI_WAIT_END = 8'h47;
   localparam logic [7:0] HI_CPU_SLOT = 8'h45;
   localparam logic [7:0] HI_SYNC_FIRST = 8'h48;
   localparam logic [7:0] HI_SYNC_LAST = 8'h97;
   localparam logic [7:0] HI_SYNC_CPU = 8'h05;
   localparam logic [2:0] SYNC_GROUP_MASK = 3'h7;
   // ------------------------------------------------------------
   // vertical timing (lines per frame, blank window, frame load line)
   // ------------------------------------------------------------
   localparam logic [SCAN_W-1:0] LINE_LAST = 8'hff;
   localparam logic [SCAN_W-1:0] VBL_FIRST = 8'hf0;
   localparam logic [SCAN_W-1:0] VSYNC_FIRST = 8'hf2;
   localparam logic [SCAN_W-1:0] VSYNC_LAST = 8'hf4;
   localparam logic [SCAN_W-1:0] LINE_ZERO = 8'h00;
   localparam logic [SCAN_W-1:0] LINE_ONE = 8'h01;
   localparam logic [2:0] BIT_ZERO = 3'h0;
   localparam logic [2:0] BIT_ONE = 3'h1;
   // ------------------------------------------------------------
   // slot kinds decoded from a pattern nibble
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      SLOT_WAIT = 2'b00,
      SLOT_FETCH = 2'b01,
      SLOT_LOAD = 2'b10,
      SLOT_CPU = 2'b11
   } bvg_slot_t;
   typedef struct packed {
      logic fetch_display_slot;
      logic load_shifter_slot;
      logic cpu_access_slot;
      logic hsync_slot;
   } bvg_pattern_t;
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic write;
   } bvg_cpu_req_t;
   localparam bvg_pattern_t PAT_FETCH = '{1'b1, 1'b0, 1'b0, 1'b0};
   localparam bvg_pattern_t PAT_LOAD = '{1'b0, 1'b1, 1'b0, 1'b0};
   localparam bvg_pattern_t PAT_CPU = '{1'b0, 1'b0, 1'b1, 1'b0};
   localparam bvg_pattern_t PAT_WAIT = '{1'b0, 1'b0, 1'b0, 1'b0};
endpackage : bvg_pkg

// ---- testbench/bvg_pixel_sink.sv ----
// monitor-side pixel receiver with switchable stalls
module bvg_pixel_sink (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // stall control from the bench
   input wire logic stall_en_i,
   // pixel stream
   input wire logic pixel_valid_i,
   input wire logic pixel_i,
   output logic pixel_ready_o,
   output int ones_cnt_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int phase = 0;
   // --------------------------------------------------------
   // receiver
   // --------------------------------------------------------
   // stalls come in bursts only, a steady slow sink would overrun any buffer
   assign pixel_ready_o = !stall_en_i || (phase < 4);
   always @(posedge clock_i) begin
      if (rst_i) begin
         phase <= 0;
         ones_cnt_o <= 0;
      end else begin
         phase <= (phase == 6) ? 0 : phase + 1;
         if (pixel_valid_i && pixel_ready_o && pixel_i === 1'b1) begin
            ones_cnt_o <= ones_cnt_o + 1;
         end
      end
   end
endmodule : bvg_pixel_sink

// ---- testbench/bvg_video_gen_bench.sv ----
// self-checking bench for the bitmap video generator
module bvg_video_gen_bench
   import bvg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_i, rst_i, req, wr, scroll_wr, blank, stall_en, ready, valid, pix;
   logic [7:0] lo_addr, wdata, bd_in, bd_out;
   logic [6:0] hi_addr;
   logic oe_n, grant, hs, vs, vb, rs, ra, rb, ca, cb;
   logic hs_d = 0, vs_d = 0, vb_d = 0, rs_d = 0, held = 0, held_pix = 0, hs_seen = 0, vs_done = 0;
   logic [31:0] seed = 32'h5f;
   logic [8:0] note;
   logic [8:0] exp_q[$];
   logic [7:0] shadow [logic [14:0]];
   int error_cnt = 0, check_count = 0, cycles = 0, ones, hs_cnt = 0, rs_cnt = 0;
   int hs_len = 0, vs_len = 0, blank_age = 0, hs_cyc = 0, vb_cyc = 0;
   // --------------------------------------------------------
   // design and partner
   // --------------------------------------------------------
   bvg_video_gen dut_u (.clock_i(clock_i), .rst_i(rst_i), .cpu_display_request_i(req),
      .cpu_write_i(wr), .buffered_address_bus_i(lo_addr), .upper_address_bus_i(hi_addr),
      .write_data_bus_i(wdata), .scroll_write_i(scroll_wr), .buffered_data_bus_i(bd_in),
      .buffered_data_bus_o(bd_out), .buffered_data_bus_oe_n_o(oe_n), .cpu_cycle_grant_o(grant),
      .display_blank_control_i(blank), .pixel_ready_i(ready), .pixel_valid_o(valid),
      .pixel_o(pix), .horizontal_sync_out_o(hs), .vertical_sync_o(vs), .vertical_blank_o(vb),
      .regulator_sync_o(rs), .row_strobe_a_o(ra), .row_strobe_b_o(rb), .col_strobe_a_o(ca),
      .col_strobe_b_o(cb));
   bvg_pixel_sink sink_u (.clock_i(clock_i), .rst_i(rst_i), .stall_en_i(stall_en),
      .pixel_valid_i(valid), .pixel_i(pix), .pixel_ready_o(ready), .ones_cnt_o(ones));
   initial begin
      clock_i = 1'b0;
      forever #12.5 clock_i = ~clock_i;
   end
   // --------------------------------------------------------
   // helpers
   // --------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic final_report();
      if (error_cnt == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : final_report
   // one processor access, held until the grant is seen
   task automatic cpu(input logic w, input logic [14:0] a, input logic [7:0] d);
      int n;
      n = 0;
      req <= 1'b1;
      wr <= w;
      {hi_addr, lo_addr} <= a;
      wdata <= d;
      exp_q.push_back({~w, w ? 8'h00 : shadow[a]});
      if (w) shadow[a] = d;
      do begin
         @(posedge clock_i);
         n++;
      end while (grant !== 1'b1 && n < 400);
      req <= 1'b0;
      check("grant wait", {31'h0, n < 400}, 32'h1);
      @(posedge clock_i);
   endtask : cpu
   // --------------------------------------------------------
   // watchers
   // --------------------------------------------------------
   always @(posedge clock_i) begin
      cycles <= cycles + 1;
      if (cycles == 130000) begin
         error_cnt++;
         final_report();
      end
   end
   always @(posedge clock_i) begin
      if (!rst_i && grant === 1'b1) begin
         if (hs_seen) check("grant slot phase", (cycles - hs_cyc) % 8, 5);
         if (exp_q.size() == 0) begin
            check("grant without request", 32'h1, 32'h0);
         end else begin
            note = exp_q.pop_front();
            check("bus enable", {31'h0, oe_n}, {31'h0, ~note[8]});
            if (note[8]) check("read byte", {24'h0, bd_out}, {24'h0, note[7:0]});
         end
      end
   end
   always @(posedge clock_i) begin
      if (!rst_i) begin
         if (held) check("held pixel", {30'h0, valid, pix}, {30'h0, 1'b1, held_pix});
         held <= valid && !ready;
         held_pix <= pix;
         blank_age <= (blank || vb) ? blank_age + 1 : 0;
         if (valid && ready && blank_age > 32) check("blanked pixel", {31'h0, pix}, 0);
         if ((ra && rb) || (ca && cb)) check("strobe pair", 1, 0);
         hs_d <= hs;
         vs_d <= vs;
         vb_d <= vb;
         rs_d <= rs;
         hs_len <= hs ? hs_len + 1 : 0;
         vs_len <= vs ? vs_len + 1 : 0;
         if (hs && !hs_d) begin
            hs_cnt <= hs_cnt + 1;
            hs_cyc <= cycles;
            hs_seen <= 1'b1;
         end
         if (!hs && hs_d) check("hsync width", hs_len, 80);
         if (rs) check("regulator pulse", {31'h0, rs_d}, 0);
         if (rs && !rs_d) rs_cnt <= rs_cnt + 1;
         if (vb && !vb_d) begin
            vb_cyc <= cycles;
            check("lines before blank", hs_cnt, 240);
            check("regulator count", rs_cnt, hs_cnt);
         end
         if (vs && !vs_d) check("vsync delay", cycles - vb_cyc, 1024);
         if (!vs && vs_d) begin
            check("vsync width", vs_len, 1536);
            vs_done <= 1'b1;
         end
      end
   end
   // --------------------------------------------------------
   // main sequence
   // --------------------------------------------------------
   initial begin
      logic [14:0] a;
      logic [7:0] d;
      rst_i = 1'b1;
      req = 1'b0;
      wr = 1'b0;
      lo_addr = 8'h00;
      hi_addr = 7'h00;
      wdata = 8'h00;
      scroll_wr = 1'b0;
      bd_in = 8'h00;
      blank = 1'b0;
      stall_en = 1'b0;
      repeat (3) @(posedge clock_i);
      check("reset outputs", {bd_out, oe_n, grant, valid, pix, hs, vs, vb, rs, ra, rb, ca, cb},
         {12'h0, 8'h00, 1'b1, 11'h000});
      rst_i <= 1'b0;
      @(posedge clock_i);
      // each read right behind its write
      for (int i = 0; i < 24; i++) begin
         a = 15'(rnd() % MEM_BYTES);
         d = 8'(rnd());
         cpu(1'b1, a, d);
         cpu(1'b0, a, d);
      end
      scroll_wr <= 1'b1;
      bd_in <= 8'(rnd());
      @(posedge clock_i);
      scroll_wr <= 1'b0;
      // light scan row 0x40, inside memory and shown on lines 0x40 and 0xc0
      for (int i = 0; i < 160; i++) cpu(1'b1, {7'h40, 8'(i)}, 8'hff);
      cpu(1'b0, {7'h40, 8'h9f}, 8'h00);
      blank <= 1'b1;
      repeat (2000) @(posedge clock_i);
      blank <= 1'b0;
      wait (cycles > 51300);
      @(posedge clock_i);
      stall_en <= 1'b1;
      repeat (300) @(posedge clock_i);
      stall_en <= 1'b0;
      while (!vs_done) @(posedge clock_i);
      // four bits per load slot, eight for the last byte of a line: 324 per lit line
      check("lit pixels", {31'h0, ones >= 648}, 1);
      final_report();
   end
endmodule : bvg_video_gen_bench
